/* cec_pkg.sv */
/*
 * Constants for the comparator event control block: register
 * addresses, field positions, reset values and settling counts.
 * Assumes one 50 MHz bus clock and an 8-bit register port.
 */
// Notes on behaviour
// [RL1] Bit 7 of the control register enables the comparator function.
// [RL2] Bit 6 picks the positive pin (0) or internal reference (1).
// [RL3] The output is high when the positive input exceeds the negative one.
// [RL4] Bit 5 is set by each compare event of the selected event mode.
// [RL5] Writing one to bit 5 clears it, writing zero leaves it alone.
// [RL6] Interrupt is requested while bit 5 and the enable in bit 4 are set.
// [RL7] Bit 3 reads back the present comparator output level.
// [RL8] Bit 3 is reset to zero and reads zero while the module is off.
// [RL9] Bit 2 drives the comparator output onto the output pin.
// [RL10] Mode bits 1:0: 00 and 10 fall, 01 rise, 11 either edge.
// [RL11] All enable, select, flag and status bits sit in one 8-bit register; edge status and mask bits sit apart in ADDR_INT_STAT and ADDR_INT_MASK.
// [RL12] With the output pin not bonded, bit 2 is reserved with no effect.
// [RL13] Leaving deep stop, or stop with reset, restores reset values.
// [RL14] The raw output passes two flip-flops before any use.
// [RL15] Edges count only while enabled; enabling makes no false event.
package cec_pkg;
	// Register addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_INT_STAT = 4'h1;
	localparam logic [3:0] ADDR_INT_MASK = 4'h2;
	// Control register field positions
	localparam int BIT_EN = 7;
	localparam int BIT_REF = 6;
	localparam int BIT_FLAG = 5;
	localparam int BIT_IE = 4;
	localparam int BIT_LIVE = 3;
	localparam int BIT_OPE = 2;
	localparam int MODE_HI = 1;
	localparam int MODE_LO = 0;
	// Interrupt status bit positions
	localparam int STAT_RISE = 0;
	localparam int STAT_FALL = 1;
	// Event mode encodings
	localparam logic [1:0] MODE_FALL0 = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL2 = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] INT_RST = 2'h0;
	// Cycles after enable before edges count
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;
	// Output pin not bonded out on this part
	localparam logic PIN_BONDED = 1'b0;
endpackage

/* cec_sync.sv */
/*
 * Two-stage level synchroniser.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ns
module cec_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Level in and out
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1_reg;
	logic stage2_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule

/* cec_top.sv */
/*
 * Comparator event control: control register, edge detection,
 * sticky event flag, interrupt and output pin drive.
 * Assumes the raw comparator level is asynchronous and a power
 * controller on clk_sys pulses lowPowerReset on deep stop exit.
 */
`timescale 1ns/1ns
module cec_top
	import cec_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic lowPowerReset,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Interrupt
	output logic irqOut,
	// Analog comparator
	input wire logic rawCompOut,
	output logic compEnable,
	output logic refSelect,
	output logic compOutPin
);
	// Whole block state, control fields first
	typedef struct packed {
		logic en;
		logic refSel;
		logic flag;
		logic ie;
		logic live;
		logic ope;
		logic [1:0] mode;
		logic prevOut;
		logic [1:0] settle;
		logic [1:0] intStat;
		logic [1:0] intMask;
		logic [7:0] rdata;
		logic irq;
		logic pin;
	} cec_state_t;

	cec_state_t s_reg;
	cec_state_t s_next;
	logic syncOut;
	logic wrCtrl;
	logic rdStat;
	logic wrMask;
	logic settled;
	logic rise;
	logic fall;
	logic evt;
	logic [7:0] ctrlView;

	// Raw level is asynchronous, two stages first
	cec_sync u_sync ( // [RL14]
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.asyncIn(rawCompOut), // high means positive above negative [RL3]
		.syncOut(syncOut)
	);

	// Register decode
	assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
	assign rdStat = regRd && (regAddr == ADDR_INT_STAT);
	assign wrMask = regWr && (regAddr == ADDR_INT_MASK);

	// Control register as software sees it
	always_comb begin
		ctrlView = CTRL_RST;
		ctrlView[BIT_EN] = s_reg.en; // [RL11]
		ctrlView[BIT_REF] = s_reg.refSel;
		ctrlView[BIT_FLAG] = s_reg.flag;
		ctrlView[BIT_IE] = s_reg.ie;
		ctrlView[BIT_LIVE] = s_reg.live; // [RL7]
		ctrlView[BIT_OPE] = s_reg.ope & PIN_BONDED; // reserved here [RL12]
		ctrlView[MODE_HI:MODE_LO] = s_reg.mode;
	end

	// Edges only after the synchroniser has refilled since enable
	assign settled = s_reg.en && (s_reg.settle == SETTLE_CYCLES); // [RL15]
	assign rise = settled && syncOut && !s_reg.prevOut;
	assign fall = settled && !syncOut && s_reg.prevOut;

	// Event mode decode
	always_comb begin
		case (s_reg.mode)
			MODE_RISE: evt = rise; // [RL10]
			MODE_BOTH: evt = rise | fall; // [RL10]
			MODE_FALL0: evt = fall; // [RL10]
			MODE_FALL2: evt = fall;
			default: evt = fall;
		endcase
	end

	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.prevOut = syncOut;
		// Control fields from software
		if (wrCtrl) begin
			s_next.en = regWdata[BIT_EN]; // [RL1]
			s_next.refSel = regWdata[BIT_REF]; // [RL2]
			s_next.ie = regWdata[BIT_IE];
			s_next.ope = regWdata[BIT_OPE];
			s_next.mode = regWdata[MODE_HI:MODE_LO];
		end
		// Count only once enable is registered: the comparator's power-up
		// swing must leave the synchroniser before edges count
		if (!s_reg.en || !s_next.en) begin
			s_next.settle = 2'h0;
		end else if (s_reg.settle != SETTLE_CYCLES) begin
			s_next.settle = s_reg.settle + 2'h1;
		end
		// Live output, forced low while off
		s_next.live = s_next.en & syncOut; // [RL8]
		// Write one clears, an event in the same cycle wins
		s_next.flag = (s_reg.flag & ~(wrCtrl & regWdata[BIT_FLAG])) // [RL5]
			| evt; // [RL4]
		// Sticky edge status, cleared by read, set wins
		s_next.intStat = (rdStat ? INT_RST : s_reg.intStat) | {fall, rise};
		if (wrMask) begin
			s_next.intMask = regWdata[1:0];
		end
		// Read data stand one cycle after the strobe
		s_next.rdata = 8'h00;
		if (regRd) begin
			case (regAddr)
				ADDR_CTRL: s_next.rdata = ctrlView;
				ADDR_INT_STAT: s_next.rdata = {6'h00, s_reg.intStat};
				ADDR_INT_MASK: s_next.rdata = {6'h00, s_reg.intMask};
				default: s_next.rdata = 8'h00;
			endcase
		end
		// Deep stop exit restores every control bit
		if (lowPowerReset) begin // [RL13]
			s_next = '0;
			s_next.prevOut = syncOut;
		end
		// Interrupt needs the enable bit; edges may add to the flag
		s_next.irq = s_next.ie
			& (s_next.flag | (|(s_next.intStat & s_next.intMask))); // [RL6]
		// Pin only where the output is bonded out
		s_next.pin = PIN_BONDED & s_next.ope & s_next.live; // [RL9] [RL12]
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs come straight from the state register
	assign regRdata = s_reg.rdata;
	assign irqOut = s_reg.irq;
	assign compEnable = s_reg.en;
	assign refSelect = s_reg.refSel;
	assign compOutPin = s_reg.pin;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	property p_enable_write;
		wrCtrl && !lowPowerReset |=> compEnable == $past(regWdata[BIT_EN]);
	endproperty
	a_enable_write: assert property (p_enable_write) // [RL1]
		else $error("enable bit not taken from write");

	property p_ref_write;
		wrCtrl && !lowPowerReset |=> refSelect == $past(regWdata[BIT_REF]);
	endproperty
	a_ref_write: assert property (p_ref_write) // [RL2]
		else $error("reference select not taken from write");

	property p_event_sets;
		evt && !lowPowerReset |=> s_reg.flag;
	endproperty
	a_event_sets: assert property (p_event_sets) // [RL4]
		else $error("compare event did not set the flag");

	property p_flag_clear;
		s_reg.flag && wrCtrl && regWdata[BIT_FLAG] && !evt
			|=> !s_reg.flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) // [RL5]
		else $error("write one did not clear the flag");

	property p_flag_keep;
		s_reg.flag && wrCtrl && !regWdata[BIT_FLAG] && !lowPowerReset
			|=> s_reg.flag;
	endproperty
	a_flag_keep: assert property (p_flag_keep) // [RL5]
		else $error("write zero disturbed the flag");

	property p_irq_gate;
		(!s_reg.ie |-> !irqOut) and (s_reg.flag && s_reg.ie |-> irqOut);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // [RL6]
		else $error("interrupt disagrees with flag and enable");

	property p_live_tracks;
		s_reg.en && $past(s_reg.en) && !$past(lowPowerReset)
			|-> s_reg.live == $past(syncOut);
	endproperty
	a_live_tracks: assert property (p_live_tracks) // [RL7]
		else $error("live bit does not follow the comparator");

	property p_live_off;
		regRd && regAddr == ADDR_CTRL && !s_reg.en |=> !regRdata[BIT_LIVE];
	endproperty
	a_live_off: assert property (p_live_off) // [RL8]
		else $error("live bit read high while disabled");

	property p_pin_reserved;
		!PIN_BONDED |-> !compOutPin;
	endproperty
	a_pin_reserved: assert property (p_pin_reserved) // [RL12]
		else $error("unbonded output pin driven");

	property p_pin_cause;
		compOutPin |-> s_reg.ope && s_reg.live;
	endproperty
	a_pin_cause: assert property (p_pin_cause) // [RL9]
		else $error("pin driven without its enable");

	property p_rise_only;
		s_reg.mode == MODE_RISE && fall && !rise && !s_reg.flag
			&& !lowPowerReset |=> !s_reg.flag;
	endproperty
	a_rise_only: assert property (p_rise_only) // [RL10]
		else $error("falling edge set flag in rising mode");

	property p_lp_reset;
		lowPowerReset |=> !compEnable && !irqOut && !s_reg.flag
			&& s_reg.mode == MODE_FALL0;
	endproperty
	a_lp_reset: assert property (p_lp_reset) // [RL13]
		else $error("low power reset left control state");

	property p_settle;
		$rose(s_reg.en) |-> !evt [*3];
	endproperty
	a_settle: assert property (p_settle) // [RL15]
		else $error("event raised while settling after enable");

	property p_settle_start;
		$rose(s_reg.en) |-> s_reg.settle == 2'h0;
	endproperty
	a_settle_start: assert property (p_settle_start) // [RL15]
		else $error("settling did not restart on enable");

	property p_no_edge_off;
		!s_reg.en |-> !evt;
	endproperty
	a_no_edge_off: assert property (p_no_edge_off) // [RL15]
		else $error("event raised while disabled");

	property p_live_zero_off;
		!s_reg.en |-> !s_reg.live;
	endproperty
	a_live_zero_off: assert property (p_live_zero_off) // [RL8]
		else $error("live bit held high while disabled");

	property p_rdata_idle;
		!regRd |=> regRdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // [RL11]
		else $error("read data outside the answer cycle");

	property p_ope_reads_zero;
		regRd && regAddr == ADDR_CTRL |=> !regRdata[BIT_OPE];
	endproperty
	a_ope_reads_zero: assert property (p_ope_reads_zero) // [RL12]
		else $error("reserved pin enable read back high");

	property p_rise_sets;
		s_reg.mode == MODE_RISE && rise && !lowPowerReset |=> s_reg.flag;
	endproperty
	a_rise_sets: assert property (p_rise_sets) // [RL10]
		else $error("rising edge missed in rising mode");

	property p_fall_only;
		(s_reg.mode == MODE_FALL0 || s_reg.mode == MODE_FALL2) && rise
			&& !s_reg.flag && !lowPowerReset |=> !s_reg.flag;
	endproperty
	a_fall_only: assert property (p_fall_only) // [RL10]
		else $error("rising edge set flag in falling mode");

	property p_both_sets;
		s_reg.mode == MODE_BOTH && (rise || fall) && !lowPowerReset
			|=> s_reg.flag;
	endproperty
	a_both_sets: assert property (p_both_sets) // [RL10]
		else $error("edge missed in either-edge mode");

	property p_irq_quiet;
		!s_reg.flag && !(|(s_reg.intStat & s_reg.intMask)) |-> !irqOut;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) // [RL6]
		else $error("interrupt raised with no cause");
endmodule

/* cec_comp_model.sv */
/*
 * Behavioural analog comparator facing the control block.
 * Assumes levels are unsigned codes standing for voltages.
 */
`timescale 1ns/1ns
module cec_comp_model (
	// Control from the block
	input wire logic compEnable,
	input wire logic refSelect,
	// Analog levels as codes
	input wire logic [7:0] posLevel,
	input wire logic [7:0] negLevel,
	input wire logic [7:0] refLevel,
	// Raw output
	output logic rawCompOut
);
	logic [7:0] nonInv;
	// Powered-down comparator idles low; a tie also reads low
	assign nonInv = refSelect ? refLevel : posLevel;
	assign rawCompOut = compEnable & (nonInv > negLevel);
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the comparator event control block.
 * Assumes the block answers reads one cycle after the strobe.
 */
`timescale 1ns/1ns
module testbench;
	import cec_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic lowPowerReset = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic irqOut, rawCompOut, compEnable, refSelect, compOutPin;
	logic [7:0] posLevel = 8'h10;
	logic [7:0] negLevel = 8'h80;
	logic [7:0] refLevel = 8'h00;
	int n_errors = 0;
	int samples_checked = 0;

	cec_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.lowPowerReset(lowPowerReset), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irqOut(irqOut), .rawCompOut(rawCompOut),
		.compEnable(compEnable), .refSelect(refSelect),
		.compOutPin(compOutPin));
	cec_comp_model u_comp (.compEnable(compEnable), .refSelect(refSelect),
		.posLevel(posLevel), .negLevel(negLevel), .refLevel(refLevel),
		.rawCompOut(rawCompOut));

	// 50 MHz bus clock
	always #10 clk_sys = ~clk_sys;

	// Bus cycles, one strobe cycle each
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		d = regRdata;
	endtask
	// Compares: register bytes and single pins
	task automatic chk8(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		samples_checked++;
		if (d !== e) begin
			n_errors++;
			$display("unexpected at %0t: reg %h got %h", $time, a, d);
		end
	endtask
	task automatic chkBit(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: pin got %b", $time, g);
		end
	endtask

	task automatic t_reset;
		chk8(ADDR_CTRL, CTRL_RST);
		chkBit(irqOut, 1'b0);
	endtask
	// Every event mode, rising then falling output
	task automatic t_modes;
		logic [1:0] md;
		for (int m = 0; m < 4; m++) begin
			md = 2'(m);
			wr(ADDR_CTRL, {6'h28, md});
			idle(6);
			posLevel <= 8'hf0;
			idle(6);
			chk8(ADDR_CTRL, {2'h2, md[0], 3'h2, md});
			wr(ADDR_CTRL, {6'h28, md});
			posLevel <= 8'h10;
			idle(6);
			chk8(ADDR_CTRL, {2'h2, md != 2'h1, 3'h0, md});
		end
	endtask
	// Flag clear by writing one, interrupt gating
	task automatic t_clear;
		wr(ADDR_CTRL, 8'hb1);
		posLevel <= 8'hf0;
		idle(6);
		chkBit(irqOut, 1'b1);
		wr(ADDR_CTRL, 8'h91);
		chk8(ADDR_CTRL, 8'hb9);
		wr(ADDR_CTRL, 8'hb1);
		chk8(ADDR_CTRL, 8'h99);
		chkBit(irqOut, 1'b0);
		wr(ADDR_CTRL, 8'h82);
		posLevel <= 8'h10;
		idle(6);
		chk8(ADDR_CTRL, 8'ha2);
		chkBit(irqOut, 1'b0);
	endtask
	// Enabling with the positive input already above the negative makes no event
	task automatic t_enable;
		wr(ADDR_CTRL, 8'h20);
		posLevel <= 8'hf0;
		idle(4);
		wr(ADDR_CTRL, 8'h83);
		idle(8);
		chk8(ADDR_CTRL, 8'h8b);
	endtask
	// Sticky status, mask and read-clear
	task automatic t_irqreg;
		logic [7:0] d;
		wr(ADDR_INT_MASK, 8'h02);
		wr(ADDR_CTRL, 8'hb1);
		rd(ADDR_INT_STAT, d);
		posLevel <= 8'h10;
		idle(6);
		chkBit(irqOut, 1'b1);
		chk8(ADDR_INT_STAT, 8'h02);
		chkBit(irqOut, 1'b0);
		chk8(ADDR_INT_STAT, 8'h00);
		chk8(ADDR_INT_MASK, 8'h02);
		chk8(4'hf, 8'h00);
	endtask
	// Reference select, reserved pin enable, disable
	task automatic t_ref;
		refLevel <= 8'hff;
		wr(ADDR_CTRL, 8'hc4);
		idle(6);
		chk8(ADDR_CTRL, 8'hc8);
		chkBit(compOutPin, 1'b0);
		chkBit(refSelect, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		chk8(ADDR_CTRL, 8'h00);
		chkBit(compEnable, 1'b0);
	endtask
	task automatic t_lowpower;
		wr(ADDR_CTRL, 8'hd3);
		lowPowerReset <= 1'b1;
		@(posedge clk_sys);
		lowPowerReset <= 1'b0;
		chk8(ADDR_CTRL, 8'h00);
		chkBit(refSelect, 1'b0);
	endtask

	task automatic print_verdict;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_modes();
		t_clear();
		t_enable();
		t_irqreg();
		t_ref();
		t_lowpower();
		print_verdict();
	end
	// Watchdog, far beyond the few hundred cycles used
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
endmodule
